// ===== testbench/bbcd_core_tb.sv
// Self-checking testbench for the branch, breakpoint and cache-op execute stage
`timescale 1ns/1ps
module bbcd_core_tb;
	import bbcd_pkg::*;
	logic         i_core_clk;
	logic         i_rst_n;
	bbcd_instr_t  i_instr;
	logic [63:0]  i_rs_val;
	logic [63:0]  i_rt_val;
	bbcd_xrsp_t   i_xrsp;
	bbcd_line_t   i_line;
	logic [3:0]   i_avs_address;
	logic         i_avs_read;
	logic         i_avs_write;
	logic [31:0]  i_avs_writedata;
	logic [3:0]   i_avs_byteenable;
	logic         o_busy;
	bbcd_branch_t o_br;
	bbcd_link_t   o_link;
	bbcd_excp_t   o_exc;
	bbcd_xreq_t   o_xreq;
	bbcd_cop_t    o_cop;
	logic [31:0]  o_avs_readdata;
	logic         o_avs_waitrequest;
	int           miscompares;
	int           checks;
	logic [63:0]  pc;
	logic [31:0]  rdata;
	bbcd_cop_t    cp;
	bbcd_excp_t   ex_seen;
	logic [4:0]   rtc [4];

	bbcd_core bbcd_core_inst (.i_core_clk, .i_rst_n, .i_instr, .i_rs_val, .i_rt_val, .o_busy,
		.o_br, .o_link, .o_exc, .o_xreq, .i_xrsp, .i_line, .o_cop, .i_avs_address,
		.i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata,
		.o_avs_waitrequest);

	always #5 i_core_clk = ~i_core_clk;

	task automatic check(input logic [69:0] seen, input logic [69:0] exp, input string msg);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %0t %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// One Avalon access; holds the request until waitrequest is sampled low
	task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge i_core_clk);
		i_avs_read <= !wr;
		i_avs_write <= wr;
		i_avs_address <= a;
		i_avs_writedata <= d;
		n = 0;
		do begin
			@(posedge i_core_clk);
			n++;
		end while (o_avs_waitrequest !== 1'b0 && n < 50);
		rdata = o_avs_readdata;
		i_avs_read <= 1'b0;
		i_avs_write <= 1'b0;
		if (n >= 50) begin
			miscompares++;
			conclude();
		end
	endtask

	// Offers one instruction and returns just after the edge that answers it
	task automatic ex(input logic [31:0] w, input logic [63:0] rs, input logic [63:0] rt);
		@(posedge i_core_clk);
		i_instr <= '{1'b1, pc, w};
		i_rs_val <= rs;
		i_rt_val <= rt;
		@(posedge i_core_clk);
		i_instr.valid <= 1'b0;
		#1;
	endtask

	task automatic br(input logic [31:0] w, input logic [63:0] rs, input logic [63:0] rt,
		input logic rd, input logic nl, input logic lk, input logic [2:0] e);
		logic [63:0] tgt;
		tgt = pc + SLOT_OFS + {{46{w[15]}}, w[15:0], 2'b00};
		ex(w, rs, rt);
		check({o_br.redirect, o_br.nullify}, {rd, nl}, "branch decision");
		if (rd) check(o_br.target, tgt, "branch target");
		check(o_link.we, lk, "link write");
		if (lk) check({o_link.addr, o_link.data}, {LINK_REG, pc + LINK_OFS}, "link");
		check({o_exc.valid, o_exc.code}, {e != 3'h0, e}, "exception");
		@(posedge i_core_clk);
		#1;
		check({o_br.redirect, o_link.we, o_exc.valid}, 3'h0, "pulse end");
	endtask

	task automatic cop(input logic [2:0] cd, input logic [1:0] c, input logic [63:0] base,
		input bbcd_xrsp_t x, input bbcd_line_t ln, input logic [2:0] e, input logic v);
		logic [63:0] va;
		va = base - 64'h8;
		i_xrsp <= x;
		i_line <= ln;
		ex({OP_CACHE, 5'h03, cd, c, 16'hFFF8}, base, 64'h0);
		check({o_xreq.valid, o_busy}, {2{e != EXC_CPU}}, "translate");
		if (e != EXC_CPU) check(o_xreq.vaddr, va, "vaddr");
		ex_seen = o_exc;
		@(posedge i_core_clk);
		#1;
		if (o_exc.valid) ex_seen = o_exc;
		cp = o_cop;
		check({ex_seen.valid, ex_seen.code}, {e != 3'h0, e}, "cache exc");
		check(cp.valid, v, "command issued");
		if (v) check({cp.cache, cp.code, cp.index, cp.dword, cp.paddr},
			{c, cd, va[CACHE_EXP-1:LINE_EXP], va[LINE_EXP-1:3], x.paddr}, "cmd");
	endtask

	initial begin
		i_core_clk = 1'b0;
		i_rst_n = 1'b0;
		i_instr = '0;
		i_rs_val = '0;
		i_rt_val = '0;
		i_xrsp = '0;
		i_line = '0;
		i_avs_address = '0;
		i_avs_read = 1'b0;
		i_avs_write = 1'b0;
		i_avs_writedata = '0;
		i_avs_byteenable = 4'hF;
		miscompares = 0;
		checks = 0;
		pc = 64'h0000_0000_0000_1000;
		rtc = '{RT_BRANCH_LT_ZERO, RT_BRANCH_LT_ZERO_LIKELY, RT_BRANCH_LT_ZERO_LINK, RT_BRANCH_LT_ZERO_LINK_LIKELY};
		repeat (20) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		av(1'b0, REG_CTRL, 32'h0);
		check(rdata, {28'h0, CTRL_RST}, "ctrl reset");
		av(1'b0, REG_PARITY_ERROR_REGISTER, 32'h0);
		check(rdata, {24'h0, PARITY_ERROR_REGISTER_RST}, "parity_error_register reset");
		av(1'b1, 4'hC, 32'hFFFF_FFFF);
		av(1'b0, 4'hC, 32'h0);
		check(rdata, 32'h0, "unmapped");
		// Operands differ only above bit 31
		br({OP_BNE, 10'h022, 16'hFFFC}, 64'h100_0000_0000, 64'h0, 1, 0, 0, 0);
		br({OP_BNE, 10'h0A5, 16'h0010}, 64'h5, 64'h5, 0, 0, 0, 0);
		br({OP_BRANCH_NOT_EQUAL_LIKELY, 10'h0A5, 16'h0010}, 64'h5, 64'h5, 0, 1, 0, 0);
		br({OP_BRANCH_NOT_EQUAL_LIKELY, 10'h0A5, 16'h0010}, 64'h5, 64'h6, 1, 0, 0, 0);
		br({OP_BRANCH_LE_ZERO_LIKELY, 10'h020, 16'h8000}, 64'h0, 64'h0, 1, 0, 0, 0);
		br({OP_BRANCH_LE_ZERO_LIKELY, 10'h020, 16'h0004}, 64'h8000_0000, 64'h0, 1, 0, 0, 0);
		br({OP_BRANCH_LE_ZERO_LIKELY, 10'h020, 16'h0004}, 64'h1, 64'h0, 0, 1, 0, 0);
		br({OP_BRANCH_LE_ZERO_LIKELY, 10'h021, 16'h0004}, 64'h0, 64'h0, 0, 0, 0, 0);
		// Source register 31 on every form, taken and not taken
		for (int i = 0; i < 4; i++) begin
			br({OP_REGISTER_IMMEDIATE_OPCODE, 5'h1F, rtc[i], 16'hFFF0}, 64'h8000_0000, 64'h0, 1, 0,
				rtc[i][4], 0);
			br({OP_REGISTER_IMMEDIATE_OPCODE, 5'h1F, rtc[i], 16'hFFF0}, 64'h7FFF_FFFF, 64'h0, 0, rtc[i][1],
				rtc[i][4], 0);
		end
		br({OP_SPECIAL, 20'hFFFFF, FN_BREAK}, 64'h0, 64'h0, 0, 0, 0, EXC_BREAK);
		av(1'b0, REG_STAT, 32'h0);
		check(rdata[2:0], EXC_BREAK, "last exception");
		av(1'b1, REG_CTRL, 32'h1);
		br({OP_REGISTER_IMMEDIATE_OPCODE, 5'h01, RT_BRANCH_LT_ZERO, 16'h0004}, 64'h8000_0000, 64'h0, 0, 0, 0, 0);
		br({OP_REGISTER_IMMEDIATE_OPCODE, 5'h01, RT_BRANCH_LT_ZERO, 16'h0004}, 64'h8000_0000_0000_0000, 64'h0, 1, 0, 0,
			0);
		br({OP_BRANCH_LE_ZERO_LIKELY, 10'h020, 16'h0004}, 64'h8000_0000, 64'h0, 0, 1, 0, 0);
		cop(CO_IDX_INV, CT_I, 64'h2000, '{32'h1234_5670, 0, 0, 0, 0}, '0, 0, 1);
		cop(CO_LD_TAG, CT_D, 64'h3F10, '{32'h1234_5678, 0, 0, 0, 0}, '0, 0, 1);
		cop(CO_HIT_INV, CT_D, 64'h2000, '{32'h0004_0000, 0, 0, 0, 0}, '{1, 0, 18'h2}, 0, 0);
		cop(CO_HIT_INV, CT_D, 64'h2000, '{32'h0004_0000, 0, 0, 0, 0}, '{0, 0, 18'h10}, 0, 0);
		cop(CO_HIT_WB, CT_D, 64'h2000, '{32'h0004_0008, 0, 0, 1, 0}, '{1, 1, 18'h10}, 0, 1);
		check({cp.wb, cp.wb_addr}, {1'b1, 18'h10, 10'h1FF, 4'h0}, "write-back address");
		// Remaining operation codes: create-dirty, store-tag, index and hit write-backs
		cop(CO_CDX, CT_D, 64'h2000, '{32'h0004_0000, 0, 0, 0, 0}, '{1, 1, 18'h2}, 0, 1);
		check(cp.wb, 1'b1, "dirty miss write-back");
		cop(CO_CDX, CT_I, 64'h2000, '{32'h0004_0000, 0, 0, 0, 0}, '0, 0, 0);
		cop(CO_ST_TAG, CT_I, 64'h2000, '{32'h0004_0000, 0, 0, 0, 0}, '0, 0, 1);
		cop(CO_IDX_INV, CT_D, 64'h2000, '{32'h0004_0000, 0, 0, 0, 0}, '{1, 1, 18'h3}, 0, 1);
		check({cp.wb, cp.wb_addr}, {1'b1, 18'h3, 10'h1FF, 4'h0}, "index write-back");
		cop(CO_HIT_WBI, CT_D, 64'h2000, '{32'h0004_0000, 0, 0, 0, 0}, '{1, 1, 18'h10}, 0, 1);
		check({cp.wb, cp.use_parity_error_register}, 2'b10, "hit write-back invalidate");
		cop(CO_HIT_INV, CT_D, 64'h2000, '{32'h0, 1, 1, 0, 0}, '0, EXC_TLB_REFILL, 0);
		cop(CO_HIT_INV, CT_D, 64'h2000, '{32'h0, 0, 1, 0, 0}, '0, EXC_TLB_INVALID, 0);
		cop(3'h7, CT_D, 64'h2000, '{32'h0, 0, 0, 0, 0}, '0, 0, 0);
		cop(CO_IDX_INV, 2'h2, 64'h2000, '{32'h0, 0, 0, 0, 0}, '0, 0, 0);
		cop(CO_IDX_INV, CT_D, 64'h2000, '{32'h0, 0, 0, 0, 1}, '0, 0, 0);
		av(1'b1, REG_PARITY_ERROR_REGISTER, 32'hA5);
		av(1'b1, REG_CTRL, 32'h8);
		cop(CO_HIT_WBI, CT_I, 64'h2000, '{32'h0004_0000, 0, 0, 0, 0}, '0, 0, 1);
		check({cp.use_parity_error_register, cp.parity_error_register}, 9'h1A5, "fill parity");
		av(1'b1, REG_CTRL, 32'h2);
		cop(CO_IDX_INV, CT_I, 64'h2000, '0, '0, EXC_CPU, 0);
		av(1'b1, REG_CTRL, 32'h6);
		cop(CO_IDX_INV, CT_I, 64'h2000, '{32'h0000_1000, 0, 0, 0, 0}, '0, 0, 1);
		conclude();
	end
endmodule

// ===== verilog/bbcd_core.sv
// Branch, breakpoint and cache-maintenance execute stage with Avalon-MM control registers
`timescale 1ns/1ps
module bbcd_core (
	input  wire logic                      i_core_clk,        // Core clock, 100 MHz
	input  wire logic                      i_rst_n,           // Async reset, active low
	input  wire bbcd_pkg::bbcd_instr_t     i_instr,           // Decoded-stage instruction
	input  wire logic [63:0]               i_rs_val,          // Source / base register value
	input  wire logic [63:0]               i_rt_val,          // Second source register value
	output logic                           o_busy,            // Stall: cache op translating
	output bbcd_pkg::bbcd_branch_t         o_br,              // PC redirect and nullify
	output bbcd_pkg::bbcd_link_t           o_link,            // Register 31 write
	output bbcd_pkg::bbcd_excp_t           o_exc,             // Exception request
	output bbcd_pkg::bbcd_xreq_t           o_xreq,            // TLB lookup request
	input  wire bbcd_pkg::bbcd_xrsp_t      i_xrsp,            // TLB answer, same cycle
	input  wire bbcd_pkg::bbcd_line_t      i_line,            // Indexed cache line state
	output bbcd_pkg::bbcd_cop_t            o_cop,             // Command to cache unit
	input  wire logic [3:0]                i_avs_address,     // Avalon byte address
	input  wire logic                      i_avs_read,        // Avalon read
	input  wire logic                      i_avs_write,       // Avalon write
	input  wire logic [31:0]               i_avs_writedata,   // Avalon write data
	input  wire logic [3:0]                i_avs_byteenable,  // Avalon byte enables
	output logic [31:0]                    o_avs_readdata,    // Avalon read data
	output logic                           o_avs_waitrequest  // Avalon wait request
);
	import bbcd_pkg::*;

	function automatic bbcd_kind_t decode(input logic [31:0] w);
		bbcd_kind_t k;
		k = K_NONE;
		unique case (w[31:26])
			OP_BNE:    k = K_BNE;
			OP_BRANCH_NOT_EQUAL_LIKELY:   k = K_BRANCH_NOT_EQUAL_LIKELY;
			OP_BRANCH_LE_ZERO_LIKELY:  k = (w[20:16] == 5'h00) ? K_BRANCH_LE_ZERO_LIKELY : K_NONE;
			OP_CACHE:  k = K_CACHE;
			OP_SPECIAL: k = (w[5:0] == FN_BREAK) ? K_BREAK : K_NONE;
			OP_REGISTER_IMMEDIATE_OPCODE: begin
				unique case (w[20:16])
					RT_BRANCH_LT_ZERO:    k = K_BRANCH_LT_ZERO;
					RT_BRANCH_LT_ZERO_LIKELY:   k = K_BRANCH_LT_ZERO_LIKELY;
					RT_BRANCH_LT_ZERO_LINK:  k = K_BRANCH_LT_ZERO_LINK;
					RT_BRANCH_LT_ZERO_LINK_LIKELY: k = K_BRANCH_LT_ZERO_LINK_LIKELY;
					default:    k = K_NONE;
				endcase
			end
			default:   k = K_NONE;
		endcase
		return k;
	endfunction

	bbcd_regs_t r_ff;
	bbcd_regs_t nxt_r;

	bbcd_kind_t        kind;
	logic              take;
	logic              m64;
	logic              sign;
	logic              is_zero;
	logic              likely;
	logic              linking;
	logic              is_branch;
	logic              accept;
	logic [63:0]       tgt_now;
	logic [63:0]       link_now;
	logic [63:0]       vaddr_now;
	logic [IDX_W-1:0]  idx;
	logic              hit;
	logic              legal;
	logic              av_req;

	function automatic logic [63:0] fit_mode(input logic [63:0] v, input logic m);
		return m ? v : {{32{v[31]}}, v[31:0]};
	endfunction

	always_comb begin
		kind      = decode(i_instr.word);
		accept    = i_instr.valid && (r_ff.st == ST_IDLE);
		m64       = r_ff.ctrl[CTRL_M64];
		sign      = m64 ? i_rs_val[63] : i_rs_val[31];
		is_zero   = m64 ? (i_rs_val == 64'h0) : (i_rs_val[31:0] == 32'h0);
		likely    = (kind == K_BRANCH_LE_ZERO_LIKELY) || (kind == K_BRANCH_LT_ZERO_LIKELY) || (kind == K_BRANCH_LT_ZERO_LINK_LIKELY)
			|| (kind == K_BRANCH_NOT_EQUAL_LIKELY);
		linking   = (kind == K_BRANCH_LT_ZERO_LINK) || (kind == K_BRANCH_LT_ZERO_LINK_LIKELY);
		is_branch = likely || linking || (kind == K_BRANCH_LT_ZERO) || (kind == K_BNE);
		unique case (kind)
			K_BRANCH_LE_ZERO_LIKELY:                     take = sign || is_zero;
			K_BRANCH_LT_ZERO, K_BRANCH_LT_ZERO_LIKELY, K_BRANCH_LT_ZERO_LINK,
			K_BRANCH_LT_ZERO_LINK_LIKELY:                   take = sign;
			K_BNE, K_BRANCH_NOT_EQUAL_LIKELY:               take = (i_rs_val != i_rt_val);
			default:                     take = 1'b0;
		endcase
		tgt_now   = fit_mode(i_instr.pc + SLOT_OFS
			+ {{46{i_instr.word[15]}}, i_instr.word[15:0], 2'b00}, m64);
		link_now  = fit_mode(i_instr.pc + LINK_OFS, m64);
		vaddr_now = i_rs_val + {{48{i_instr.word[15]}}, i_instr.word[15:0]};
	end

	always_comb begin
		idx   = r_ff.xreq.vaddr[CACHE_EXP-1:LINE_EXP];
		hit   = i_line.valid && (i_line.tag == i_xrsp.paddr[PA_W-1:CACHE_EXP]);
		legal = ((r_ff.pend_cache == CT_I) || (r_ff.pend_cache == CT_D))
			&& (r_ff.pend_code != 3'h7)
			&& !((r_ff.pend_code == CO_CDX) && (r_ff.pend_cache == CT_I))
			&& !i_xrsp.uncached;
		av_req = i_avs_read || i_avs_write;
	end

	always_comb begin
		nxt_r              = r_ff;
		nxt_r.br           = '0;
		nxt_r.link         = '0;
		nxt_r.exc          = '0;
		nxt_r.xreq.valid   = 1'b0;
		nxt_r.cop          = '0;

		unique case (r_ff.st)
			ST_IDLE: begin
				if (accept && is_branch) begin
					nxt_r.br.redirect = take;
					nxt_r.br.target   = tgt_now;
					nxt_r.br.nullify  = likely && !take;
				end
				if (accept && linking) begin
					nxt_r.link.we   = 1'b1;
					nxt_r.link.addr = LINK_REG;
					nxt_r.link.data = link_now;
				end
				if (accept && (kind == K_BREAK)) begin
					// Code field bits 25..6 are never looked at
					nxt_r.exc.valid = 1'b1;
					nxt_r.exc.code  = EXC_BREAK;
				end
				if (accept && (kind == K_CACHE)) begin
					if (r_ff.ctrl[CTRL_USER] && !r_ff.ctrl[CTRL_CU0]) begin
						nxt_r.exc.valid = 1'b1;
						nxt_r.exc.code  = EXC_CPU;
					end else begin
						nxt_r.st         = ST_XLATE;
						nxt_r.xreq.valid = 1'b1;
						nxt_r.xreq.vaddr = vaddr_now;
						nxt_r.pend_cache = i_instr.word[17:16];
						nxt_r.pend_code  = i_instr.word[20:18];
					end
				end
			end
			ST_XLATE: begin
				nxt_r.st = ST_IDLE;
				// TLB modified is never reported for a cache op
				if (i_xrsp.refill) begin
					nxt_r.exc.valid = 1'b1;
					nxt_r.exc.code  = EXC_TLB_REFILL;
				end else if (i_xrsp.invalid) begin
					nxt_r.exc.valid = 1'b1;
					nxt_r.exc.code  = EXC_TLB_INVALID;
				end else if (legal) begin
					nxt_r.cop.cache   = r_ff.pend_cache;
					nxt_r.cop.code    = r_ff.pend_code;
					nxt_r.cop.index   = idx;
					nxt_r.cop.dword   = r_ff.xreq.vaddr[LINE_EXP-1:3];
					nxt_r.cop.paddr   = i_xrsp.paddr;
					nxt_r.cop.wb_addr = {i_line.tag, idx, {LINE_EXP{1'b0}}};
					nxt_r.cop.parity_error_register    = r_ff.parity_error_register;
					unique case (r_ff.pend_code)
						CO_IDX_INV: begin
							nxt_r.cop.valid = 1'b1;
							nxt_r.cop.wb    = (r_ff.pend_cache == CT_D)
								&& i_line.valid && i_line.dirty;
						end
						CO_LD_TAG, CO_ST_TAG: nxt_r.cop.valid = 1'b1;
						CO_CDX: begin
							nxt_r.cop.valid = 1'b1;
							nxt_r.cop.wb    = !hit && i_line.valid && i_line.dirty;
						end
						CO_HIT_INV: nxt_r.cop.valid = hit;
						CO_HIT_WBI: begin
							if (r_ff.pend_cache == CT_I) begin
								nxt_r.cop.valid    = 1'b1;
								nxt_r.cop.use_parity_error_register = r_ff.ctrl[CTRL_CE];
							end else begin
								nxt_r.cop.valid = hit;
								nxt_r.cop.wb    = hit && i_line.dirty;
							end
						end
						CO_HIT_WB: begin
							nxt_r.cop.valid = hit;
							nxt_r.cop.wb    = hit && ((r_ff.pend_cache == CT_I)
								|| i_line.dirty);
						end
						default: nxt_r.cop.valid = 1'b0;
					endcase
				end
			end
			default: nxt_r.st = ST_IDLE;
		endcase
		if (nxt_r.exc.valid) begin
			nxt_r.last_exc = nxt_r.exc.code;
		end

		// Avalon slave: first edge latches data, waitrequest drops the next cycle
		nxt_r.av_ack = av_req && !r_ff.av_ack;
		if (av_req && !r_ff.av_ack) begin
			unique case (i_avs_address)
				REG_CTRL: nxt_r.av_rdata = {28'h0, r_ff.ctrl};
				REG_PARITY_ERROR_REGISTER: nxt_r.av_rdata = {24'h0, r_ff.parity_error_register};
				REG_STAT: nxt_r.av_rdata = {27'h0, r_ff.st == ST_XLATE, 1'b0,
					3'(r_ff.last_exc)};
				default:  nxt_r.av_rdata = 32'h0;
			endcase
		end
		if (i_avs_write && r_ff.av_ack && i_avs_byteenable[0]) begin
			if (i_avs_address == REG_CTRL) begin
				nxt_r.ctrl = i_avs_writedata[3:0];
			end
			if (i_avs_address == REG_PARITY_ERROR_REGISTER) begin
				nxt_r.parity_error_register = i_avs_writedata[PARITY_ERROR_REGISTER_W-1:0];
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			r_ff          <= '0;
			r_ff.st       <= ST_IDLE;
			r_ff.ctrl     <= CTRL_RST;
			r_ff.parity_error_register     <= PARITY_ERROR_REGISTER_RST;
			r_ff.last_exc <= EXC_NONE;
		end else begin
			r_ff <= nxt_r;
		end
	end

	assign o_busy            = (r_ff.st != ST_IDLE);
	assign o_br              = r_ff.br;
	assign o_link            = r_ff.link;
	assign o_exc             = r_ff.exc;
	assign o_xreq            = r_ff.xreq;
	assign o_cop             = r_ff.cop;
	assign o_avs_readdata    = r_ff.av_rdata;
	assign o_avs_waitrequest = av_req && !r_ff.av_ack;

	// Checks
	sequence s_cache_issue;
		accept && (kind == K_CACHE) && !(r_ff.ctrl[CTRL_USER] && !r_ff.ctrl[CTRL_CU0]);
	endsequence
	sequence s_hit_miss;
		(r_ff.pend_code == CO_HIT_INV) && !hit;
	endsequence

	property p_target;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		accept && is_branch && take |=> o_br.redirect && (o_br.target == $past(tgt_now));
	endproperty
	a_target: assert property (p_target) else $error("branch target wrong");

	property p_redirect_time;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		o_br.redirect |-> $past(accept && is_branch && take);
	endproperty
	a_redirect_time: assert property (p_redirect_time) else $error("late redirect");

	property p_branch_le_zero_likely;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		accept && (kind == K_BRANCH_LE_ZERO_LIKELY) && !sign && !is_zero |=> !o_br.redirect && o_br.nullify;
	endproperty
	a_branch_le_zero_likely: assert property (p_branch_le_zero_likely) else $error("branch_le_zero_likely taken wrongly");

	property p_nullify;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		o_br.nullify |-> !o_br.redirect && $past(likely);
	endproperty
	a_nullify: assert property (p_nullify) else $error("bad nullify");

	property p_link;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		accept && linking |=> o_link.we && (o_link.addr == LINK_REG)
			&& (o_link.data == $past(link_now));
	endproperty
	a_link: assert property (p_link) else $error("link write missing");

	property p_bne;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		accept && (kind == K_BNE) && (i_rs_val == i_rt_val) |=> !o_br.redirect;
	endproperty
	a_bne: assert property (p_bne) else $error("bne taken on equal");

	property p_break;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		accept && (kind == K_BREAK) |=> o_exc.valid && (o_exc.code == EXC_BREAK);
	endproperty
	a_break: assert property (p_break) else $error("break not raised");

	property p_cpu;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		accept && (kind == K_CACHE) && r_ff.ctrl[CTRL_USER] && !r_ff.ctrl[CTRL_CU0]
			|=> o_exc.valid && (o_exc.code == EXC_CPU) && !o_xreq.valid;
	endproperty
	a_cpu: assert property (p_cpu) else $error("cpu unusable missed");

	property p_xlate;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		s_cache_issue |=> o_xreq.valid && o_busy ##1 !o_busy;
	endproperty
	a_xlate: assert property (p_xlate) else $error("translate step wrong");

	property p_hit_miss;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(r_ff.st == ST_XLATE) and s_hit_miss |=> !o_cop.valid;
	endproperty
	a_hit_miss: assert property (p_hit_miss) else $error("hit op on miss");

	property p_uncached;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(r_ff.st == ST_XLATE) && i_xrsp.uncached |=> !o_cop.valid;
	endproperty
	a_uncached: assert property (p_uncached) else $error("uncached op issued");
endmodule

// ===== verilog/bbcd_pkg.sv
// Constants, types and state layout of the branch, breakpoint and cache-op decoder
// Summary of operation
// - Branch target is delay-slot address plus sign-extended offset shifted left two.
// - A taken branch redirects the PC in the cycle after evaluation.
// - Likely less-or-equal-zero branch taken on sign bit set or register zero.
// - Likely branches nullify the delay-slot instruction when not taken.
// - Less-than-zero branches taken exactly when the sign bit is set.
// - Linking branches always write PC plus 8 into register 31.
// - Linking branch with source register 31 runs without any trap.
// - Not-equal branches compare both registers in full, taken when different.
// - Breakpoint raises its exception at once, without condition.
// - The 20-bit breakpoint code field is ignored by hardware.
// - Cache op address is base plus sign-extended offset, translated by the TLB.
// - Instruction bits 17 to 16 select the target cache.
// - Non-kernel mode with coprocessor enable clear gives coprocessor unusable.
// - Index ops select the block from address bits between size exponents.
// - Index load-tag picks the parity doubleword from line-offset bits down to 3.
// - With parity enable set, fill writes parity error register values.
// - Hit ops act only on a valid block whose tag matches.
// - Write-back address is rebuilt from the stored tag.
// - Cache ops may take TLB refill or invalid, never TLB modified.
// - Opcodes 000101 and 010101 decode the two not-equal branches; 010110 with rt zero decodes the likely le-zero branch.
// - Register-immediate rt codes 00000, 10000, 10010, 00010 pick the lt-zero forms.
// - Opcode 101111 is the cache op; function 001101 under special is breakpoint.
// - Instruction bits 20 to 18 give the cache operation code.
package bbcd_pkg;
	localparam int          XLEN       = 64;
	localparam int          PA_W       = 32;
	localparam int          CACHE_EXP  = 14;
	localparam int          LINE_EXP   = 4;
	localparam int          IDX_W      = CACHE_EXP - LINE_EXP;
	localparam int          DW_W       = LINE_EXP - 3;
	localparam int          PTAG_W     = PA_W - CACHE_EXP;
	localparam int          PARITY_ERROR_REGISTER_W     = 8;
	localparam logic [5:0]  OP_SPECIAL = 6'h00;
	localparam logic [5:0]  OP_REGISTER_IMMEDIATE_OPCODE  = 6'h01;
	localparam logic [5:0]  OP_BNE     = 6'h05;
	localparam logic [5:0]  OP_BRANCH_NOT_EQUAL_LIKELY    = 6'h15;
	localparam logic [5:0]  OP_BRANCH_LE_ZERO_LIKELY   = 6'h16;
	localparam logic [5:0]  OP_CACHE   = 6'h2F;
	localparam logic [5:0]  FN_BREAK   = 6'h0D;
	localparam logic [4:0]  RT_BRANCH_LT_ZERO    = 5'h00;
	localparam logic [4:0]  RT_BRANCH_LT_ZERO_LIKELY   = 5'h02;
	localparam logic [4:0]  RT_BRANCH_LT_ZERO_LINK  = 5'h10;
	localparam logic [4:0]  RT_BRANCH_LT_ZERO_LINK_LIKELY = 5'h12;
	localparam logic [4:0]  LINK_REG   = 5'h1F;
	localparam logic [63:0] SLOT_OFS   = 64'h4;
	localparam logic [63:0] LINK_OFS   = 64'h8;
	localparam logic [1:0]  CT_I       = 2'h0;
	localparam logic [1:0]  CT_D       = 2'h1;
	localparam logic [2:0]  CO_IDX_INV = 3'h0;
	localparam logic [2:0]  CO_LD_TAG  = 3'h1;
	localparam logic [2:0]  CO_ST_TAG  = 3'h2;
	localparam logic [2:0]  CO_CDX     = 3'h3;
	localparam logic [2:0]  CO_HIT_INV = 3'h4;
	localparam logic [2:0]  CO_HIT_WBI = 3'h5;
	localparam logic [2:0]  CO_HIT_WB  = 3'h6;
	localparam logic [3:0]  REG_CTRL   = 4'h0;
	localparam logic [3:0]  REG_PARITY_ERROR_REGISTER   = 4'h4;
	localparam logic [3:0]  REG_STAT   = 4'h8;
	localparam int          CTRL_M64   = 0;
	localparam int          CTRL_USER  = 1;
	localparam int          CTRL_CU0   = 2;
	localparam int          CTRL_CE    = 3;
	localparam logic [3:0]  CTRL_RST   = 4'h0;
	localparam logic [7:0]  PARITY_ERROR_REGISTER_RST   = 8'h00;

	typedef enum logic [1:0] {ST_IDLE, ST_XLATE} bbcd_state_t;
	typedef enum logic [2:0] {EXC_NONE, EXC_BREAK, EXC_CPU, EXC_TLB_REFILL,
		EXC_TLB_INVALID} bbcd_exc_t;
	typedef enum logic [3:0] {K_NONE, K_BRANCH_LE_ZERO_LIKELY, K_BRANCH_LT_ZERO, K_BRANCH_LT_ZERO_LIKELY, K_BRANCH_LT_ZERO_LINK, K_BRANCH_LT_ZERO_LINK_LIKELY,
		K_BNE, K_BRANCH_NOT_EQUAL_LIKELY, K_BREAK, K_CACHE} bbcd_kind_t;

	typedef struct packed {logic valid; logic [63:0] pc; logic [31:0] word;} bbcd_instr_t;
	typedef struct packed {logic redirect; logic nullify; logic [63:0] target;} bbcd_branch_t;
	typedef struct packed {logic we; logic [4:0] addr; logic [63:0] data;} bbcd_link_t;
	typedef struct packed {logic valid; bbcd_exc_t code;} bbcd_excp_t;
	typedef struct packed {logic valid; logic [63:0] vaddr;} bbcd_xreq_t;
	typedef struct packed {
		logic [PA_W-1:0] paddr;
		logic            refill;
		logic            invalid;
		logic            modified;
		logic            uncached;
	} bbcd_xrsp_t;
	typedef struct packed {logic valid; logic dirty; logic [PTAG_W-1:0] tag;} bbcd_line_t;
	typedef struct packed {
		logic              valid;
		logic [1:0]        cache;
		logic [2:0]        code;
		logic [IDX_W-1:0]  index;
		logic [DW_W-1:0]   dword;
		logic [PA_W-1:0]   paddr;
		logic              wb;
		logic [PA_W-1:0]   wb_addr;
		logic              use_parity_error_register;
		logic [PARITY_ERROR_REGISTER_W-1:0] parity_error_register;
	} bbcd_cop_t;
	typedef struct packed {
		bbcd_state_t       st;
		bbcd_branch_t      br;
		bbcd_link_t        link;
		bbcd_excp_t        exc;
		bbcd_xreq_t        xreq;
		bbcd_cop_t         cop;
		logic [1:0]        pend_cache;
		logic [2:0]        pend_code;
		logic [3:0]        ctrl;
		logic [PARITY_ERROR_REGISTER_W-1:0] parity_error_register;
		bbcd_exc_t         last_exc;
		logic              av_ack;
		logic [31:0]       av_rdata;
	} bbcd_regs_t;
endpackage
